/* include/scr_pkg.sv */
// shared constants and types for the serial nand cache read unit
package scr_pkg;
  // command opcodes
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST = 8'h0B;
  localparam logic [7:0] OP_X2 = 8'h3B;
  localparam logic [7:0] OP_X4 = 8'h6B;
  localparam logic [7:0] OP_DIO = 8'hBB;
  localparam logic [7:0] OP_QIO = 8'hEB;
  localparam logic [7:0] OP_DTR = 8'hEE;
  localparam logic [7:0] OP_ID = 8'h9F;
  localparam logic [7:0] OP_LOAD = 8'h13;
  localparam logic [7:0] OP_GETF = 8'h0F;
  localparam logic [7:0] OP_SETF = 8'h1F;
  // feature register addresses
  localparam logic [7:0] FA_PROT = 8'hA0;
  localparam logic [7:0] FA_CFG = 8'hB0;
  localparam logic [7:0] FA_STAT = 8'hC0;
  // field positions and reset values
  localparam int CFG_QE_BIT = 0;
  localparam int CFG_OTP_BIT = 6;
  localparam int STAT_BUSY_BIT = 0;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // special rows loaded with the one-time area enabled
  localparam logic [23:0] ROW_UID = 24'h000000;
  localparam logic [23:0] ROW_PARAM = 24'h000001;
  // cache geometry: 2048 data plus 128 spare bytes
  localparam int CACHE_DEPTH = 2176;
  // address phase lengths in bits
  localparam logic [5:0] ABITS_COL = 6'h10;
  localparam logic [5:0] ABITS_DTR = 6'h20;
  localparam logic [5:0] ABITS_FEAT = 6'h08;
  localparam logic [5:0] ABITS_SETF = 6'h10;
  localparam logic [5:0] ABITS_ROW = 6'h18;
  // dummy phase lengths in serial clocks
  localparam logic [3:0] DUM_BYTE = 4'h8;
  localparam logic [3:0] DUM_DIO = 4'h4;
  localparam logic [3:0] DUM_QIO = 4'h2;
  localparam logic [3:0] DUM_DTR = 4'h8;
  // what a command does
  typedef enum logic [2:0] {
    K_CACHE,
    K_ID,
    K_GETF,
    K_SETF,
    K_LOAD
  } scr_kind_t;
  // decoded command
  typedef struct packed {
    logic ok;
    scr_kind_t kind;
    logic [2:0] in_lanes;
    logic [5:0] abits;
    logic [3:0] dummy;
    logic [2:0] out_lanes;
    logic ddr;
  } scr_cmd_t;
  // what the load engine writes into the cache
  typedef enum logic [1:0] {
    L_NONE,
    L_UID,
    L_PARAM
  } scr_load_t;
endpackage

/* hw/scr_cache_mem.sv */
// cache byte memory with one write port and a registered read port
`timescale 1ns/10ps
`default_nettype none
module scr_cache_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2176,
  parameter int AW = 12
) (
  // clock
  input wire logic clock,
  // write side
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // read side
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  // write and registered read
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

/* hw/scr_cache_read_unit.sv */
// serial nand cache read, identification and special page load unit
// What this block does
// R1: x4 cache read needs quad enable set
// R2: dual io takes address, 4 dummy clocks
// R3: dual io data out two bits per clock
// R4: start any column, increment after each byte
// R5: quad io takes address plus one dummy byte
// R6: quad io data out four bits per clock
// R7: quad io read needs quad enable set
// R8: dtr quad read needs quad enable set
// R9: dtr moves four bits on both edges
// R10: dtr address increments, rolls to zero
// R11: id read gives maker then part byte
// R12: uid bytes then complement, 32 byte group
// R13: uid group repeated sixteen times or more
// R14: host checks uid xor complement all ones
// R15: host enables otp, loads row zero, polls
// R16: host enables otp, loads row one, polls
// R17: parameter structure repeated at least three times
// R18: cache reads allowed while page load runs
// R19: single, x2, x4 reads use 8 dummy clocks
// R20: cache output wraps at page end
// R21: page load busy, polled via feature read
// R22: x2 read: input one line, output two
`timescale 1ns/10ps
`default_nettype none
module scr_cache_read_unit #(
  parameter int DEPTH = scr_pkg::CACHE_DEPTH,
  parameter logic [7:0] MAKER_CODE = 8'hA5, // arbitrary value
  parameter logic [7:0] PART_CODE = 8'h5A, // arbitrary value
  parameter logic [127:0] UNIQUE_ID = 128'h0123456789ABCDEF0F1E2D3C4B5A6978
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // serial link
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [3:0] serial_io_line_in,
  output logic [3:0] serial_io_line_out,
  output logic [3:0] serial_io_line_oe,
  // array side cache fill
  input wire logic fill_en,
  input wire logic [$clog2(DEPTH)-1:0] fill_addr,
  input wire logic [7:0] fill_data,
  // array side status
  output logic busy,
  output logic page_load,
  output logic [23:0] page_row,
  output logic quad_enable_bit
);
  import scr_pkg::*;

  localparam int AW = $clog2(DEPTH);

  typedef enum logic [2:0] {
    S_CMD,
    S_ADDR,
    S_DUMMY,
    S_DATA,
    S_IDLE
  } scr_state_t;

  // command table
  function automatic scr_cmd_t decode(input logic [7:0] op, input logic qe);
    scr_cmd_t c;
    c = '{ok: 1'b1, kind: K_CACHE, in_lanes: 3'd1, abits: ABITS_COL,
          dummy: DUM_BYTE, out_lanes: 3'd1, ddr: 1'b0};
    unique case (op)
      OP_READ, OP_FAST: ; // see R19
      OP_X2: c.out_lanes = 3'd2; // see R22
      OP_X4: begin
        c.out_lanes = 3'd4;
        c.ok = qe; // see R1
      end
      OP_DIO: begin
        c.in_lanes = 3'd2; // see R2
        c.dummy = DUM_DIO;
        c.out_lanes = 3'd2; // see R3
      end
      OP_QIO: begin
        c.in_lanes = 3'd4; // see R5
        c.dummy = DUM_QIO;
        c.out_lanes = 3'd4; // see R6
        c.ok = qe; // see R7
      end
      OP_DTR: begin
        c.in_lanes = 3'd4; // see R9
        c.abits = ABITS_DTR;
        c.dummy = DUM_DTR;
        c.out_lanes = 3'd4;
        c.ddr = 1'b1;
        c.ok = qe; // see R8
      end
      OP_ID: begin
        c.kind = K_ID;
        c.abits = 6'h00;
      end
      OP_GETF: begin
        c.kind = K_GETF; // see R21
        c.abits = ABITS_FEAT;
        c.dummy = 4'h0;
      end
      OP_SETF: begin
        c.kind = K_SETF;
        c.abits = ABITS_SETF;
      end
      OP_LOAD: begin
        c.kind = K_LOAD;
        c.abits = ABITS_ROW;
      end
      default: c.ok = 1'b0;
    endcase
    return c;
  endfunction

  // shift incoming lanes into the address register
  function automatic logic [31:0] shift_in(input logic [31:0] s,
                                           input logic [3:0] io,
                                           input logic [2:0] lanes);
    unique case (lanes)
      3'd1: return {s[30:0], io[0]};
      3'd2: return {s[29:0], io[1:0]};
      default: return {s[27:0], io};
    endcase
  endfunction

  // top bits of a byte placed on the output lines
  function automatic logic [3:0] pins_of(input logic [7:0] b,
                                         input logic [2:0] lanes);
    unique case (lanes)
      3'd1: return {2'b00, b[7], 1'b0};
      3'd2: return {2'b00, b[7:6]};
      default: return b[7:4];
    endcase
  endfunction

  // next column with wrap at the page end
  function automatic logic [AW-1:0] col_inc(input logic [AW-1:0] p);
    return (32'(p) == DEPTH - 1) ? '0 : p + 1'b1;
  endfunction

  // feature register read value
  function automatic logic [7:0] feat_val(input logic [7:0] a,
                                          input logic [7:0] cfg_v,
                                          input logic busy_v);
    if (a == FA_CFG) begin
      return cfg_v;
    end else if (a == FA_STAT) begin
      return 8'(busy_v) << STAT_BUSY_BIT;
    end
    return 8'h00;
  endfunction

  // parameter page structure, one 256 byte copy
  function automatic logic [7:0] param_byte(input logic [7:0] i,
                                            input logic [7:0] maker);
    unique case (i)
      8'h00: return 8'h4F;
      8'h01: return 8'h4E;
      8'h02: return 8'h46;
      8'h03: return 8'h49;
      8'h40: return maker;
      8'h51, 8'h61: return 8'h08;
      8'h54: return 8'h80;
      8'h57: return 8'h02;
      8'h5A: return 8'h20;
      8'h5C: return 8'h40;
      8'h64, 8'h66, 8'h6B: return 8'h01;
      8'h67: return 8'h28;
      8'h69: return 8'h05;
      8'h6A, 8'h6E: return 8'h04;
      default: return 8'h00;
    endcase
  endfunction

  // byte written by the load engine at a cache index
  function automatic logic [7:0] gen_byte(input scr_load_t m,
                                          input logic [AW-1:0] i,
                                          input logic [127:0] unique_identifier,
                                          input logic [7:0] maker);
    logic [127:0] t;
    t = unique_identifier >> {~i[3:0], 3'b000};
    if (m == L_UID) begin
      return i[4] ? ~t[7:0] : t[7:0]; // see R12, R13
    end
    return param_byte(i[7:0], maker); // see R17
  endfunction

  // pin synchronisers
  logic cs_m, cs_s, sclk_m, sclk_s, sclk_d;
  logic [3:0] io_m, io_s;
  // link state
  scr_state_t state;
  scr_cmd_t cmd;
  logic [31:0] shreg;
  logic [5:0] cnt;
  logic [AW-1:0] rptr;
  logic [7:0] outb;
  logic [3:0] bits_left;
  logic id_sel;
  logic [7:0] feat_addr;
  logic [7:0] cfg;
  // load engine
  scr_load_t ld_mode;
  logic [AW-1:0] ld_idx;
  logic [7:0] rd_data;

  // two flops on every pin, a third on the clock for edges
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cs_m <= 1'b1;
      cs_s <= 1'b1;
      sclk_m <= 1'b0;
      sclk_s <= 1'b0;
      sclk_d <= 1'b0;
      io_m <= 4'h0;
      io_s <= 4'h0;
    end else begin
      cs_m <= cs_n;
      cs_s <= cs_m;
      sclk_m <= sclk;
      sclk_s <= sclk_m;
      sclk_d <= sclk_s;
      io_m <= serial_io_line_in;
      io_s <= io_m;
    end
  end

  // edge detection and phase decode
  logic rise, fall, cap, shift_edge, op_done, addr_done, dum_done;
  logic enter_data, next_byte, load_byte, start_load;
  logic [31:0] shin;
  logic [5:0] acnt;
  scr_cmd_t dec;
  logic [7:0] faddr, src;
  logic [AW-1:0] col_start;
  logic [7:0] row_byte;
  assign rise = sclk_s & ~sclk_d;
  assign fall = ~sclk_s & sclk_d;
  assign cap = rise | (cmd.ddr & fall); // see R9
  assign shift_edge = fall | (cmd.ddr & rise); // see R9
  assign op_done = (state == S_CMD) && rise && (cnt == 6'h07);
  assign dec = decode({shreg[6:0], io_s[0]}, cfg[CFG_QE_BIT]);
  assign shin = shift_in(shreg, io_s, cmd.in_lanes);
  assign acnt = cnt + {3'b000, cmd.in_lanes};
  assign addr_done = (state == S_ADDR) && cap && (acnt == cmd.abits);
  assign dum_done = (state == S_DUMMY) && rise &&
                    (cnt + 6'h01 == {2'b00, cmd.dummy});
  assign enter_data = (addr_done && cmd.kind == K_GETF) || dum_done;
  assign next_byte = (state == S_DATA) && shift_edge && (bits_left == 4'h0);
  assign load_byte = enter_data || next_byte;
  assign start_load = addr_done && (cmd.kind == K_LOAD) && !busy;
  assign faddr = (state == S_ADDR) ? shin[7:0] : feat_addr;
  assign col_start = (32'(shin[AW-1:0]) >= DEPTH) ? '0 : shin[AW-1:0];
  assign row_byte = (cmd.kind == K_ID) ? (id_sel ? PART_CODE : MAKER_CODE) :
                    (cmd.kind == K_GETF) ? feat_val(faddr, cfg, busy) :
                    rd_data;
  assign src = row_byte;

  // command, address, dummy and data phases
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= S_CMD;
      cmd <= '0;
      shreg <= 32'h0;
      cnt <= 6'h00;
      rptr <= '0;
      outb <= 8'h00;
      bits_left <= 4'h0;
      id_sel <= 1'b0;
      feat_addr <= 8'h00;
      cfg <= CFG_RESET;
      serial_io_line_out <= 4'h0;
      serial_io_line_oe <= 4'h0;
    end else if (cs_s) begin
      state <= S_CMD;
      cnt <= 6'h00;
      id_sel <= 1'b0;
      serial_io_line_oe <= 4'h0; // release the lines on deselect
    end else begin
      unique case (state)
        S_CMD: if (rise) begin
          shreg <= {shreg[30:0], io_s[0]};
          cnt <= (cnt == 6'h07) ? 6'h00 : cnt + 6'h01;
          if (op_done) begin
            cmd <= dec;
            state <= !dec.ok ? S_IDLE :
                     (dec.abits == 6'h00) ? S_DUMMY : S_ADDR;
          end
        end
        S_ADDR: if (cap) begin
          shreg <= shin; // see R2, R5
          cnt <= addr_done ? 6'h00 : acnt;
          if (addr_done) begin
            feat_addr <= shin[7:0];
            rptr <= col_start; // see R4
            state <= (cmd.kind == K_GETF) ? S_DATA :
                     (cmd.kind == K_CACHE) ? S_DUMMY : S_IDLE;
            if (cmd.kind == K_SETF && shin[15:8] == FA_CFG) begin
              cfg <= shin[7:0];
            end
          end
        end
        S_DUMMY: if (rise) begin
          cnt <= cnt + 6'h01; // see R19
          if (dum_done) begin
            state <= S_DATA;
          end
        end
        S_DATA: if (shift_edge && !next_byte) begin
          outb <= outb << cmd.out_lanes;
          bits_left <= bits_left - {1'b0, cmd.out_lanes};
          serial_io_line_out <= pins_of(outb << cmd.out_lanes,
                                        cmd.out_lanes);
        end
        S_IDLE: ;
      endcase
      // first and later bytes of the data phase
      if (load_byte) begin
        outb <= src;
        bits_left <= 4'h8 - {1'b0, cmd.out_lanes};
        serial_io_line_out <= pins_of(src, cmd.out_lanes); // see R3, R6
        serial_io_line_oe <= (cmd.out_lanes == 3'd1) ? 4'h2 :
                             (cmd.out_lanes == 3'd2) ? 4'h3 : 4'hF;
        id_sel <= ~id_sel; // see R11
        if (cmd.kind == K_CACHE) begin
          rptr <= col_inc(rptr); // see R4, R10, R20
        end
      end
    end
  end

  // page load engine: busy for one pass over the cache
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      busy <= 1'b0;
      ld_mode <= L_NONE;
      ld_idx <= '0;
      page_load <= 1'b0;
      page_row <= 24'h0;
    end else begin
      page_load <= start_load;
      if (start_load) begin
        busy <= 1'b1; // see R21
        ld_idx <= '0;
        page_row <= shin[23:0];
        ld_mode <= !cfg[CFG_OTP_BIT] ? L_NONE :
                   (shin[23:0] == ROW_UID) ? L_UID :
                   (shin[23:0] == ROW_PARAM) ? L_PARAM : L_NONE;
      end else if (busy) begin
        ld_idx <= ld_idx + 1'b1;
        busy <= (32'(ld_idx) != DEPTH - 1);
      end
    end
  end

  // cache write: load engine first, then array fill
  logic gen_wr, wr_en;
  logic [AW-1:0] wr_addr;
  logic [7:0] wr_data;
  assign gen_wr = busy && (ld_mode != L_NONE);
  assign wr_en = gen_wr || fill_en;
  assign wr_addr = gen_wr ? ld_idx : fill_addr;
  assign wr_data = gen_wr ? gen_byte(ld_mode, ld_idx, UNIQUE_ID, MAKER_CODE)
                          : fill_data;
  assign quad_enable_bit = cfg[CFG_QE_BIT];

  // cache read runs beside the load, see R18
  scr_cache_mem #(
    .WIDTH(8),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_cache (
    .clock(clock),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_addr(rptr),
    .rd_data(rd_data)
  );
endmodule
`default_nettype wire

/* sim/scr_checker.sv */
// assertion checker watching the cache read unit ports
`timescale 1ns/10ps
`default_nettype none
module scr_checker #(
  parameter int DEPTH = 2176
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // link side
  input wire logic cs_n,
  input wire logic [3:0] serial_io_line_oe,
  // status side
  input wire logic busy,
  input wire logic page_load,
  input wire logic [23:0] page_row,
  input wire logic quad_enable_bit
);
  int busy_cnt;
  int cs_hi_cnt;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // run lengths of busy and of deselect
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      busy_cnt <= 0;
      cs_hi_cnt <= 0;
    end else begin
      busy_cnt <= busy ? busy_cnt + 1 : 0;
      cs_hi_cnt <= cs_n ? cs_hi_cnt + 1 : 0;
    end
  end
  // a load is a single pulse followed by busy
  sequence s_load;
    page_load ##1 (busy && !page_load) ##1 busy;
  endsequence
  AST_LOAD_BUSY: assert property (page_load |-> s_load)
    else $error("load pulse not followed by busy");
  AST_BUSY_LEN: assert property ($fell(busy) |->
    busy_cnt >= DEPTH - 1 && busy_cnt <= DEPTH + 1)
    else $error("busy period has wrong length");
  AST_BUSY_CAUSE: assert property ($rose(busy) |->
    page_load || $past(page_load)) else $error("busy without load");
  AST_ROW_CAUSE: assert property ($changed(page_row) |->
    (page_load || $past(page_load)) or ##1 page_load)
    else $error("row changed without load");
  AST_OE_SHAPE: assert property (serial_io_line_oe inside
    {4'h0, 4'h2, 4'h3, 4'hF}) else $error("illegal lane enable set");
  AST_OE_RELEASE: assert property (cs_n [*6] |->
    serial_io_line_oe == 4'h0) else $error("lines driven after deselect");
  AST_OE_START: assert property ($rose(serial_io_line_oe != 4'h0) |->
    !cs_n) else $error("drive started while deselected");
  AST_QE_GATE: assert property (!quad_enable_bit |->
    serial_io_line_oe != 4'hF) else $error("four lanes without quad enable");
  AST_QE_WHEN: assert property ($changed(quad_enable_bit) |->
    cs_hi_cnt < 8) else $error("quad enable changed outside a command");
endmodule
bind scr_cache_read_unit scr_checker #(.DEPTH(DEPTH)) chk_u (
  .clock(clock), .resetn(resetn), .cs_n(cs_n),
  .serial_io_line_oe(serial_io_line_oe), .busy(busy),
  .page_load(page_load), .page_row(page_row),
  .quad_enable_bit(quad_enable_bit));
`default_nettype wire

/* sim/scr_host_model.sv */
// host controller model driving the serial link
`timescale 1ns/10ps
`default_nettype none
module scr_host_model (
  // pacing clock
  input wire logic clock,
  // device side of the io lines
  input wire logic [3:0] serial_io_line_out,
  input wire logic [3:0] serial_io_line_oe,
  // link outputs
  output logic cs_n,
  output logic sclk,
  output logic [3:0] serial_io_line_in
);
  logic [3:0] drv = 4'h0;
  logic [7:0] rx[$];
  logic seen_oe = 1'b0;
  logic [3:0] q_lo = 4'h0;
  // idle link: deselected, clock parked low
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
  end
  // wire level: device drive where its enables are set, host drive on the other lines
  assign serial_io_line_in = (serial_io_line_oe & serial_io_line_out) |
      (~serial_io_line_oe & drv);
  // note any device drive within a frame
  always @(posedge clock) begin
    if (!cs_n && serial_io_line_oe != 4'h0) seen_oe <= 1'b1;
  end
  // one link period: lines set while low, sampled at end of high
  task automatic cyc(input logic [3:0] d, output logic [3:0] q);
    sclk = 1'b0;
    drv = d;
    repeat (4) @(negedge clock);
    q_lo = serial_io_line_out;
    sclk = 1'b1;
    repeat (4) @(negedge clock);
    q = serial_io_line_out;
  endtask
  // whole frame: opcode, address, dummy, then n bytes in
  task automatic cmd(input logic [7:0] op, input logic [31:0] a,
      input int ab, input int al, input int dum, input int n, input int ol);
    logic [3:0] q;
    logic [7:0] b;
    rx.delete();
    seen_oe = 1'b0;
    cs_n = 1'b0;
    repeat (4) @(negedge clock);
    for (int i = 7; i >= 0; i--) cyc({3'h0, op[i]}, q);
    for (int i = 0; i < ab / al; i++) begin
      cyc(4'((a >> (ab - al * (i + 1))) & ((1 << al) - 1)), q);
    end
    repeat (dum) cyc(~drv, q);
    // first bits leave on the edge that ends dummy or address, so q
    // already holds them here
    repeat (n) begin
      b = 8'h00;
      repeat (8 / ol) begin
        b = (ol == 1) ? {b[6:0], q[1]} :
            8'((b << ol) | (q & 4'((1 << ol) - 1)));
        cyc(~drv, q);
        // ol of 8: high nibble before the fall, low nibble after it
        if (ol == 8) b = {b[3:0], q_lo};
      end
      rx.push_back(b);
    end
    sclk = 1'b0;
    drv = ~drv;
    repeat (4) @(negedge clock);
    cs_n = 1'b1;
    repeat (8) @(negedge clock);
  endtask
endmodule
`default_nettype wire

/* sim/scr_cache_read_unit_bench.sv */
// self-checking bench for the cache read unit
`timescale 1ns/10ps
`default_nettype none
module scr_cache_read_unit_bench;
  import scr_pkg::*;
  localparam int DEPTH = 768;
  localparam logic [7:0] MAKER = 8'h3C; // arbitrary value
  localparam logic [7:0] PART = 8'hC3; // arbitrary value
  logic clock, resetn, cs_n, sclk, fill_en, busy, page_load, qe;
  logic [3:0] io_in, io_out, io_oe;
  logic [9:0] fill_addr;
  logic [7:0] fill_data;
  logic [23:0] page_row;
  int n_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  int n_loads = 0;
  // clock source
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  scr_cache_read_unit #(.DEPTH(DEPTH), .MAKER_CODE(MAKER),
      .PART_CODE(PART)) dut_u (.clock(clock), .resetn(resetn),
      .cs_n(cs_n), .sclk(sclk), .serial_io_line_in(io_in),
      .serial_io_line_out(io_out), .serial_io_line_oe(io_oe),
      .fill_en(fill_en), .fill_addr(fill_addr), .fill_data(fill_data),
      .busy(busy), .page_load(page_load), .page_row(page_row),
      .quad_enable_bit(qe));
  scr_host_model host_u (.clock(clock), .serial_io_line_out(io_out),
      .serial_io_line_oe(io_oe), .cs_n(cs_n), .sclk(sclk),
      .serial_io_line_in(io_in));
  // cycle ceiling and load pulse count
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (page_load === 1'b1) n_loads <= n_loads + 1;
    if (cycles == 40000) begin
      n_errors++;
      final_report();
    end
  end
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic final_report();
    $display("checks %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // cache fill pattern
  function automatic logic [7:0] pat(input int i);
    return 8'((i % DEPTH) * 5 + (i % DEPTH) / 256);
  endfunction
  // feature access helpers
  task automatic setf(input logic [7:0] a, input logic [7:0] d);
    host_u.cmd(OP_SETF, {16'h0, a, d}, 16, 1, 0, 0, 1);
  endtask
  task automatic getf(input logic [7:0] a);
    host_u.cmd(OP_GETF, 32'(a), 8, 1, 0, 1, 1);
  endtask
  // wait out a page load through status reads
  task automatic poll();
    for (int i = 0; i < 20; i++) begin
      getf(FA_STAT);
      if (host_u.rx[0][STAT_BUSY_BIT] === 1'b0) break;
    end
    check(host_u.rx[0][STAT_BUSY_BIT], 0);
  endtask
  // fill the cache through the array port
  task automatic t_fill();
    for (int i = 0; i < DEPTH; i++) begin
      fill_en = 1'b1;
      fill_addr = 10'(i);
      fill_data = pat(i);
      @(negedge clock);
    end
    fill_en = 1'b0;
    setf(FA_CFG, 8'h01);
    check(qe, 1);
    host_u.cmd(OP_GETF, 32'(FA_CFG), 8, 1, 0, 2, 1);
    check(host_u.rx[1], 8'h01);
    $display("test fill and quad enable done");
  endtask
  // every cache read mode across the wrap point
  task automatic t_reads();
    logic [7:0] ops[7] = '{OP_READ, OP_FAST, OP_X2, OP_X4, OP_DIO, OP_QIO,
        OP_DTR};
    int al[7] = '{1, 1, 1, 1, 2, 4, 4};
    int dm[7] = '{8, 8, 8, 8, 4, 2, 8};
    int ol[7] = '{1, 1, 2, 4, 2, 4, 8};
    int col;
    logic [31:0] ad;
    for (int k = 0; k < 7; k++) begin
      col = DEPTH - 6 + k;
      ad = 32'(col);
      // dtr takes each nibble on both edges: 2F arrives as column 2FF
      if (k == 6) begin
        col = 10'h2FF;
        ad = 32'h0000002F;
      end
      host_u.cmd(ops[k], ad, 16, al[k], dm[k], 8, ol[k]);
      check(host_u.seen_oe, 1);
      for (int j = 0; j < 8; j++) begin
        check(host_u.rx[j], pat(col + j));
      end
    end
    $display("test cache reads done");
  endtask
  // quad commands refused with quad enable clear
  task automatic t_refuse();
    logic [7:0] ops[3] = '{OP_X4, OP_QIO, OP_DTR};
    setf(FA_CFG, 8'h00);
    check(qe, 0);
    for (int k = 0; k < 3; k++) begin
      host_u.cmd(ops[k], 32'h0, 16, (k == 0) ? 1 : 4, 8, 2, 4);
      check(host_u.seen_oe, 0);
    end
    $display("test refusal done");
  endtask
  // identification bytes
  task automatic t_id();
    host_u.cmd(OP_ID, 32'h0, 0, 1, 8, 4, 1);
    for (int j = 0; j < 4; j++) check(host_u.rx[j], j % 2 ? PART : MAKER);
    $display("test id done");
  endtask
  // identifier load, poll and copies
  task automatic t_uid();
    int l0;
    setf(FA_CFG, 8'h40);
    getf(FA_CFG);
    check(host_u.rx[0], 8'h40);
    l0 = n_loads;
    host_u.cmd(OP_LOAD, 32'(ROW_UID), 24, 1, 0, 0, 1);
    check(n_loads - l0, 1);
    check(page_row, ROW_UID);
    check(busy, 1);
    poll();
    host_u.cmd(OP_READ, 32'h0, 16, 1, 8, 64, 1);
    for (int j = 0; j < 16; j++) begin
      check(host_u.rx[j] ^ host_u.rx[j + 16], 8'hFF);
    end
    for (int j = 0; j < 32; j++) check(host_u.rx[j + 32], host_u.rx[j]);
    $display("test unique identifier done");
  endtask
  // parameter page read while loading, then its copies
  task automatic t_param();
    host_u.cmd(OP_LOAD, 32'(ROW_PARAM), 24, 1, 0, 0, 1);
    check(page_row, ROW_PARAM);
    check(busy, 1);
    host_u.cmd(OP_READ, 32'd64, 16, 1, 8, 1, 1);
    check(host_u.rx[0], MAKER);
    poll();
    for (int c = 1; c < 3; c++) begin
      host_u.cmd(OP_READ, 32'(64 + 256 * c), 16, 1, 8, 1, 1);
      check(host_u.rx[0], MAKER);
    end
    $display("test parameter page done");
  endtask
  // reset, then the scenarios in turn
  initial begin
    resetn = 1'b0;
    fill_en = 1'b0;
    fill_addr = 10'h000;
    fill_data = 8'h00;
    repeat (12) @(negedge clock);
    resetn = 1'b1;
    repeat (4) @(negedge clock);
    t_fill();
    t_reads();
    t_refuse();
    t_id();
    t_uid();
    t_param();
    final_report();
  end
endmodule
`default_nettype wire
